// file: verilog/sdoc_ctl_end.sv
// Controller end: APB registers drive the termination pin, commands
// and mode fields; the pin is held high for the minimum time.
// Assumes an APB master on pclk; one wait state on every access.
`default_nettype none
module sdoc_ctl_end
  import sdoc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  sdoc_link_if.ctl         link
);

  sdoc_ctl_st_t s_reg;
  sdoc_ctl_st_t s_next;

  logic [3:0]  hold;
  logic [31:0] rdval;
  logic        mapped;
  logic        wr_cmd;
  logic        req;

  always_comb begin
    s_next = s_reg;
    s_next.rd = 1'b0;
    s_next.wr = 1'b0;
    wr_cmd = 1'b0;
    req = s_reg.ctrl[`SDOC_CTRL_REQ];

    // Longer hold with CRC or long preamble
    hold = (s_reg.ctrl[`SDOC_CTRL_CHOP] ? `SDOC_HOLD_CHOP
                                          : `SDOC_HOLD_FULL)
         + {3'h0, s_reg.ctrl[`SDOC_CTRL_PRE2]}
         + {3'h0, s_reg.ctrl[`SDOC_CTRL_CRC]};

    mapped = 1'b1;
    case (paddr)
      `SDOC_CTRL_OFS: rdval = s_reg.ctrl;
      `SDOC_LAT_OFS:  rdval = s_reg.lat;
      `SDOC_MR_OFS:   rdval = s_reg.mr;
      `SDOC_CMD_OFS:  rdval = 32'h0000_0000;
      `SDOC_STAT_OFS: rdval = {25'h0, link.term_code, link.term_sel,
                               s_reg.st == SDOC_ST_HOLD, s_reg.pin};
      default: begin
        rdval  = 32'h0000_0000;
        mapped = 1'b0;
      end
    endcase

    if (psel && penable && !s_reg.pready) begin
      s_next.pready  = 1'b1;
      s_next.prdata  = pwrite ? 32'h0000_0000 : rdval;
      s_next.pslverr = !mapped;
    end else begin
      s_next.pready  = 1'b0;
      s_next.pslverr = 1'b0;
      // Writes land on the edge that completes the transfer
      if (psel && penable && pwrite && mapped) begin
        case (paddr)
          `SDOC_CTRL_OFS: s_next.ctrl = pwdata;
          `SDOC_LAT_OFS:  s_next.lat  = pwdata;
          `SDOC_MR_OFS:   s_next.mr   = pwdata;
          `SDOC_CMD_OFS: begin
            s_next.chop = pwdata[`SDOC_CMD_CHOP];
            case (pwdata[1:0])
              `SDOC_CMD_RD: s_next.rd = 1'b1;
              `SDOC_CMD_WR: begin
                s_next.wr = 1'b1;
                wr_cmd = 1'b1;
              end
              `SDOC_CMD_WRCLR: s_next.mr[6:4] = 3'h0;
              default: s_next.rd = 1'b0;
            endcase
          end
          default: s_next.rd = 1'b0;
        endcase
      end
    end

    case (s_reg.st)
      SDOC_ST_LOW: begin
        if (req) begin
          s_next.pin = 1'b1;
          s_next.hold_cnt = 4'h0;
          s_next.st = SDOC_ST_HOLD;
        end
      end
      SDOC_ST_HOLD: begin
        if (s_reg.hold_cnt >= 4'(hold - 4'h1)) begin
          s_next.st  = req ? SDOC_ST_FREE : SDOC_ST_LOW;
          s_next.pin = req;
        end else begin
          s_next.hold_cnt = 4'(s_reg.hold_cnt + 4'h1);
        end
      end
      SDOC_ST_FREE: begin
        if (!req) begin
          s_next.pin = 1'b0;
          s_next.st  = SDOC_ST_LOW;
        end
      end
      default: begin
        s_next.pin = 1'b0;
        s_next.st  = SDOC_ST_LOW;
      end
    endcase

    // A write while high restarts the hold count
    if (wr_cmd && s_reg.pin && s_next.pin) begin
      s_next.hold_cnt = 4'h0;
      s_next.st = SDOC_ST_HOLD;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg      <= '0;
      s_reg.ctrl <= `SDOC_CTRL_RST;
      s_reg.lat  <= `SDOC_LAT_RST;
      s_reg.mr   <= `SDOC_MR_RST;
      s_reg.st   <= SDOC_ST_LOW;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata          = s_reg.prdata;
  assign pready          = s_reg.pready;
  assign pslverr         = s_reg.pslverr;
  assign link.term_pin   = s_reg.pin;
  assign link.cmd_rd     = s_reg.rd;
  assign link.cmd_wr     = s_reg.wr;
  assign link.cmd_chop   = s_reg.chop;
  assign link.mr_nom     = s_reg.mr[2:0];
  assign link.mr_wr      = s_reg.mr[6:4];
  assign link.mr_park    = s_reg.mr[10:8];
  assign link.cwl        = s_reg.lat[5:0];
  assign link.al         = s_reg.lat[13:8];
  assign link.pl         = s_reg.lat[19:16];
  assign link.cl         = s_reg.lat[29:24];
  assign link.pre2       = s_reg.ctrl[`SDOC_CTRL_PRE2];
  assign link.crc_en     = s_reg.ctrl[`SDOC_CTRL_CRC];
  assign link.fixed_chop = s_reg.ctrl[`SDOC_CTRL_CHOP];
  assign link.dll_on     = s_reg.ctrl[`SDOC_CTRL_DLL];
  assign link.self_ref   = s_reg.ctrl[`SDOC_CTRL_SREF];

endmodule
`default_nettype wire

// file: verilog/sdoc_map.svh
// Constants of the termination timing block: offsets, fields, resets
// and cycle figures. Assumes inclusion by bare name from the package.
`ifndef SDOC_MAP_SVH
`define SDOC_MAP_SVH

// History depth covers the longest latency plus the longest window
`define SDOC_HIST_DEPTH     128
`define SDOC_IDX_W          7
`define SDOC_WIN_MAX        8

// Latency trims for one- and two-cycle preamble
`define SDOC_ADJ_PRE1       7'h02
`define SDOC_ADJ_PRE2       7'h03

// Read park-return offsets
`define SDOC_RD_CHOP_LEN    4'h4
`define SDOC_RD_FULL_LEN    4'h6

// Write release offsets: one-cycle preamble, CRC off / on
`define SDOC_WR_CHOP_LEN    4'h4
`define SDOC_WR_CHOP_CRC    4'h7
`define SDOC_WR_FULL_LEN    4'h6
`define SDOC_WR_FULL_CRC    4'h7

// Minimum pin high time in cycles
`define SDOC_HOLD_CHOP      4'h4
`define SDOC_HOLD_FULL      4'h6

// Change skew window in hundredths of a clock (analog, not modelled)
`define SDOC_SKEW_MIN_LOW   30
`define SDOC_SKEW_MAX_LOW   70
`define SDOC_SKEW_MIN_TOP   26
`define SDOC_SKEW_MAX_TOP   74

// Controller register offsets
`define SDOC_CTRL_OFS       12'h000
`define SDOC_LAT_OFS        12'h004
`define SDOC_MR_OFS         12'h008
`define SDOC_CMD_OFS        12'h00c
`define SDOC_STAT_OFS       12'h010

// CTRL fields
`define SDOC_CTRL_REQ       0
`define SDOC_CTRL_CHOP      1
`define SDOC_CTRL_CRC       2
`define SDOC_CTRL_PRE2      3
`define SDOC_CTRL_DLL       4
`define SDOC_CTRL_SREF      5

// CMD fields and kinds
`define SDOC_CMD_CHOP       2
`define SDOC_CMD_RD         2'h1
`define SDOC_CMD_WR         2'h2
`define SDOC_CMD_WRCLR      2'h3

// Reset values
`define SDOC_CTRL_RST       32'h0000_0010
`define SDOC_LAT_RST        32'h0b00_0009
`define SDOC_MR_RST         32'h0000_0000

`endif

// file: verilog/sdoc_pkg.sv
// Types shared by both ends of the termination timing link.
// Assumes sdoc_map.svh on the include path.
`default_nettype none
package sdoc_pkg;
`include "sdoc_map.svh"

  typedef enum logic [1:0] {
    SDOC_TERM_OFF  = 2'h0,
    SDOC_TERM_NOM  = 2'h1,
    SDOC_TERM_WR   = 2'h2,
    SDOC_TERM_PARK = 2'h3
  } sdoc_term_t;

  typedef enum logic [2:0] {
    SDOC_ST_LOW  = 3'h1,
    SDOC_ST_HOLD = 3'h2,
    SDOC_ST_FREE = 3'h4
  } sdoc_pin_st_t;

  typedef logic [`SDOC_HIST_DEPTH-1:0] sdoc_hist_t;
  typedef logic [`SDOC_IDX_W-1:0]      sdoc_idx_t;

  typedef struct packed {
    sdoc_hist_t pin_hist;
    sdoc_hist_t rd_hist;
    sdoc_hist_t wr_hist;
    sdoc_hist_t chop_hist;
    sdoc_term_t term_sel;
    logic [2:0] term_code;
    logic       rd_quiet;
    logic       wr_on;
    sdoc_idx_t  pin_delay;
    sdoc_idx_t  rd_delay;
  } sdoc_dev_st_t;

  typedef struct packed {
    logic [31:0]  ctrl;
    logic [31:0]  lat;
    logic [31:0]  mr;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic         pin;
    logic         rd;
    logic         wr;
    logic         chop;
    logic [3:0]   hold_cnt;
    sdoc_pin_st_t st;
  } sdoc_ctl_st_t;

endpackage
`default_nettype wire

// file: verilog/sdoc_link_if.sv
// Link between memory controller and the device termination logic.
// Both ends run on the same pclk; all signals are synchronous levels.
`default_nettype none
interface sdoc_link_if;
  import sdoc_pkg::*;

  logic       term_pin;
  logic       cmd_rd;
  logic       cmd_wr;
  logic       cmd_chop;
  logic [2:0] mr_nom;
  logic [2:0] mr_wr;
  logic [2:0] mr_park;
  logic [5:0] cwl;
  logic [5:0] al;
  logic [5:0] cl;
  logic [3:0] pl;
  logic       pre2;
  logic       crc_en;
  logic       fixed_chop;
  logic       dll_on;
  logic       self_ref;
  sdoc_term_t term_sel;
  logic [2:0] term_code;

  modport dev (
    input  term_pin, cmd_rd, cmd_wr, cmd_chop, mr_nom, mr_wr, mr_park,
    input  cwl, al, cl, pl, pre2, crc_en, fixed_chop, dll_on, self_ref,
    output term_sel, term_code
  );

  modport ctl (
    output term_pin, cmd_rd, cmd_wr, cmd_chop, mr_nom, mr_wr, mr_park,
    output cwl, al, cl, pl, pre2, crc_en, fixed_chop, dll_on, self_ref,
    input  term_sel, term_code
  );
endinterface
`default_nettype wire

// file: verilog/sdoc_dev_end.sv
// Device end: synchronous termination timing, read disable window,
// dynamic write termination and the precedence between them.
// Assumes all link inputs change just after rising pclk edges.
`default_nettype none

// What this block does
// - Synchronous timing whenever DLL on and locked
// - Nominal on/off delayed after pin registered
// - Pin delays are CWL+AL+PL minus 2/3
// - Read turns termination off after CL-based delay
// - Parked returns four or six cycles later, five or seven with long preamble
// - Controller holds pin high minimum time
// - Controller lengthens hold for CRC, long preamble
// - Hold counted from pin high or write
// - Value change settles inside skew window; not modelled, value switches on the edge
// - Never terminate while driving read data
// - Dynamic termination on when A9 or A10 set
// - Values from MR1, MR2 and MR5 fields
// - Nominal follows pin, parked while pin low
// - Writes select then release write termination
// - Write select delay is WL minus 2/3
// - Release offset by burst, preamble and CRC
// - No dynamic termination with DLL off
// - Controller clears write field to disable
// - Precedence: disable, write, nominal, parked
// - Read disable starts RL minus 2/3
// - Pin ignored if nominal zero or self refresh
module sdoc_dev_end
  import sdoc_pkg::*;
(
  input  wire logic   pclk,
  input  wire logic   presetn,
  sdoc_link_if.dev    link,
  output logic        rd_quiet,
  output logic        wr_term_on,
  output logic [6:0]  pin_delay,
  output logic [6:0]  rd_delay
);

  sdoc_dev_st_t s_reg;
  sdoc_dev_st_t s_next;

  logic [6:0] adj;
  logic [6:0] wl;
  logic [6:0] rl;
  logic [6:0] d_pin;
  logic [6:0] d_rd;
  logic [3:0] rd_len;
  logic [3:0] chop_len;
  logic [3:0] full_len;
  logic [3:0] this_len;
  logic [6:0] idx;
  logic       pin_eff;
  logic       dyn_en;
  logic       nom_on;
  logic       rd_off;
  logic       wr_sel;

  // Clamp keeps a tap index legal for nonsense latency settings
  function automatic logic [6:0] sdoc_clamp(input logic [6:0] d);
    sdoc_clamp = (d == 7'h00) ? 7'h01 : d;
  endfunction

  always_comb begin
    s_next   = s_reg;
    idx      = 7'h00;
    this_len = 4'h0;

    adj = link.pre2 ? `SDOC_ADJ_PRE2 : `SDOC_ADJ_PRE1;
    wl  = 7'({1'b0, link.cwl} + {1'b0, link.al} + {3'h0, link.pl});
    rl  = 7'({1'b0, link.cl} + {1'b0, link.al} + {3'h0, link.pl});
    d_pin = sdoc_clamp(7'(wl - adj));
    d_rd  = sdoc_clamp(7'(rl - adj));

    // Parked return offset: fixed chop vs full/on-the-fly
    rd_len = (link.fixed_chop ? `SDOC_RD_CHOP_LEN : `SDOC_RD_FULL_LEN)
           + {3'h0, link.pre2};

    // Release offsets per burst kind
    if (link.crc_en) begin
      chop_len = `SDOC_WR_CHOP_CRC + {3'h0, link.pre2};
      full_len = `SDOC_WR_FULL_CRC + {3'h0, link.pre2};
    end else begin
      chop_len = `SDOC_WR_CHOP_LEN + {3'h0, link.pre2};
      full_len = `SDOC_WR_FULL_LEN + {3'h0, link.pre2};
    end

    // Pin ignored when nominal disabled or in self refresh
    pin_eff = link.term_pin && (link.mr_nom != 3'h0)
              && !link.self_ref;

    // Enable bits are A9/A10 only; DLL-off forbids it
    dyn_en = (link.mr_wr[0] || link.mr_wr[1]) && link.dll_on;

    // Histories: bit k holds what was registered k edges ago
    s_next.pin_hist  = {s_reg.pin_hist[`SDOC_HIST_DEPTH-2:0], pin_eff};
    s_next.rd_hist   = {s_reg.rd_hist[`SDOC_HIST_DEPTH-2:0], link.cmd_rd};
    s_next.wr_hist   = {s_reg.wr_hist[`SDOC_HIST_DEPTH-2:0],
                        link.cmd_wr && dyn_en};
    s_next.chop_hist = {s_reg.chop_hist[`SDOC_HIST_DEPTH-2:0],
                        link.cmd_chop || link.fixed_chop};

    // Nominal follows the pin after the direct latency
    if (link.dll_on) begin
      nom_on = s_reg.pin_hist[7'(d_pin - 7'h01)];
    end else begin
      // DLL-off timing belongs elsewhere; follow pin with no latency
      nom_on = pin_eff;
    end

    // Read window: off from the read delay until parked return
    rd_off = 1'b0;
    for (int i = 0; i < `SDOC_WIN_MAX; i++) begin
      idx = 7'(d_rd - 7'h01 + 7'(i));
      if ((4'(i) < rd_len) && s_reg.rd_hist[idx]) begin
        rd_off = 1'b1;
      end
    end

    // Write window: each write carries its own burst length
    wr_sel = 1'b0;
    for (int i = 0; i < `SDOC_WIN_MAX; i++) begin
      idx = 7'(d_pin - 7'h01 + 7'(i));
      this_len = s_reg.chop_hist[idx] ? chop_len : full_len;
      if ((4'(i) < this_len) && s_reg.wr_hist[idx]) begin
        wr_sel = 1'b1;
      end
    end

    // Precedence resolution; self refresh turns termination off
    if (link.self_ref || rd_off) begin
      s_next.term_sel  = SDOC_TERM_OFF;
      s_next.term_code = 3'h0;
    end else if (wr_sel) begin
      s_next.term_sel  = SDOC_TERM_WR;
      s_next.term_code = link.mr_wr;
    end else if (nom_on) begin
      s_next.term_sel  = SDOC_TERM_NOM;
      s_next.term_code = link.mr_nom;
    end else if (link.mr_park != 3'h0) begin
      s_next.term_sel  = SDOC_TERM_PARK;
      s_next.term_code = link.mr_park;
    end else begin
      s_next.term_sel  = SDOC_TERM_OFF;
      s_next.term_code = 3'h0;
    end

    s_next.rd_quiet  = rd_off || link.self_ref;
    s_next.wr_on     = wr_sel;
    s_next.pin_delay = d_pin;
    s_next.rd_delay  = d_rd;
  end

  // Value switches on the edge; skew is analog and not modelled.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign link.term_sel  = s_reg.term_sel;
  assign link.term_code = s_reg.term_code;
  assign rd_quiet       = s_reg.rd_quiet;
  assign wr_term_on     = s_reg.wr_on;
  assign pin_delay      = s_reg.pin_delay;
  assign rd_delay       = s_reg.rd_delay;

endmodule
`default_nettype wire

// file: testbench/sdoc_props.sv
// Concurrent checks on the termination link between both ends.
// Assumes one clock domain and instantiation beside the link.
`default_nettype none
module sdoc_props
  import sdoc_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       term_pin,
  input wire logic       cmd_rd,
  input wire logic       cmd_wr,
  input wire logic [2:0] mr_nom,
  input wire logic [2:0] mr_wr,
  input wire logic [2:0] mr_park,
  input wire logic       pre2,
  input wire logic       crc_en,
  input wire logic       fixed_chop,
  input wire logic       dll_on,
  input wire logic       self_ref,
  input wire sdoc_term_t term_sel,
  input wire logic [2:0] term_code
);
  logic [7:0] off_cnt_reg;

  // Saturates so a long DLL-off stretch never wraps back to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) off_cnt_reg <= 8'h00;
    else if (dll_on) off_cnt_reg <= 8'h00;
    else if (off_cnt_reg != 8'hff) off_cnt_reg <= off_cnt_reg + 8'h01;
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence hold_short;
    term_pin [*4];
  endsequence
  sequence hold_full;
    term_pin [*6];
  endsequence

  chk_hold_min: assert property ($rose(term_pin) |-> hold_short)
    else $error("pin dropped before minimum high time");
  chk_hold_long: assert property (
    $rose(term_pin) && !fixed_chop && !pre2 && !crc_en |-> hold_full)
    else $error("pin dropped before full burst high time");
  chk_rd_pulse: assert property (cmd_rd |=> !cmd_rd)
    else $error("read command longer than one cycle");
  chk_wr_pulse: assert property (cmd_wr |=> !cmd_wr)
    else $error("write command longer than one cycle");
  chk_nom_code: assert property (
    term_sel == SDOC_TERM_NOM && $stable(mr_nom) |-> term_code == mr_nom)
    else $error("nominal code does not follow its field");
  chk_wr_code: assert property (
    term_sel == SDOC_TERM_WR && $stable(mr_wr) |-> term_code == mr_wr)
    else $error("write code does not follow its field");
  chk_park_code: assert property (
    term_sel == SDOC_TERM_PARK && $stable(mr_park) |-> term_code == mr_park)
    else $error("parked code does not follow its field");
  chk_nom_gate: assert property (
    term_sel == SDOC_TERM_NOM |-> mr_nom != 3'h0)
    else $error("nominal applied with nominal field zero");
  chk_sref_off: assert property (
    self_ref [*2] |=> term_sel == SDOC_TERM_OFF)
    else $error("termination on during self refresh");
  chk_dll_nowr: assert property (
    off_cnt_reg >= 8'hc8 |-> term_sel != SDOC_TERM_WR)
    else $error("write termination with DLL off");
  cov_write: cover property (cmd_wr ##7 term_sel == SDOC_TERM_WR);
endmodule
`default_nettype wire

// file: testbench/sdoc_tb.sv
// Bench joining controller end and device end over the link.
// Assumes APB access to the controller registers, one 250 MHz clock.
`default_nettype none
module sdoc_tb
  import sdoc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rd_quiet;
  logic        wr_term_on;
  logic [6:0]  pin_delay;
  logic [6:0]  rd_delay;
  logic [31:0] rdat;
  logic        rerr;
  int          bad_count = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          wl;
  int          rl;
  int          lw;
  int          lr;

  sdoc_link_if sdoc_link_if_i ();

  sdoc_ctl_end sdoc_ctl_end_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(sdoc_link_if_i));

  sdoc_dev_end sdoc_dev_end_i (.pclk(pclk), .presetn(presetn),
    .link(sdoc_link_if_i), .rd_quiet(rd_quiet), .wr_term_on(wr_term_on),
    .pin_delay(pin_delay), .rd_delay(rd_delay));

  sdoc_props sdoc_props_i (.pclk(pclk), .presetn(presetn),
    .term_pin(sdoc_link_if_i.term_pin), .cmd_rd(sdoc_link_if_i.cmd_rd),
    .cmd_wr(sdoc_link_if_i.cmd_wr), .mr_nom(sdoc_link_if_i.mr_nom),
    .mr_wr(sdoc_link_if_i.mr_wr), .mr_park(sdoc_link_if_i.mr_park),
    .pre2(sdoc_link_if_i.pre2), .crc_en(sdoc_link_if_i.crc_en),
    .fixed_chop(sdoc_link_if_i.fixed_chop),
    .dll_on(sdoc_link_if_i.dll_on), .self_ref(sdoc_link_if_i.self_ref),
    .term_sel(sdoc_link_if_i.term_sel),
    .term_code(sdoc_link_if_i.term_code));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Generous ceiling; the full sequence needs well under 5000 cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      print_verdict;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    // A missing answer counts as a mismatch
    if (pready !== 1'b1) begin
      bad_count++;
      $display("unexpected at %0t: no pready", $time);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic evt(input int w);
    case (w)
      0: return sdoc_link_if_i.term_pin;
      1: return !sdoc_link_if_i.term_pin;
      2: return sdoc_link_if_i.cmd_rd;
      default: return sdoc_link_if_i.cmd_wr;
    endcase
  endfunction

  // Event seen after edge j is registered at j+1; checks sit either
  // side of the switching edge and of the window end when len > 0
  task probe(input int w, input int n, input int len,
             input logic [1:0] idle, input logic [1:0] act);
    int k;
    k = 0;
    #1;
    while (!evt(w) && k < 60) begin
      @(posedge pclk);
      #1;
      k++;
    end
    if (!evt(w)) begin
      bad_count++;
      $display("unexpected at %0t: awaited event missing", $time);
    end
    repeat (n) @(posedge pclk);
    #1;
    chk(32'(sdoc_link_if_i.term_sel), 32'(idle));
    @(posedge pclk);
    #1;
    chk(32'(sdoc_link_if_i.term_sel), 32'(act));
    chk(32'(wr_term_on), 32'(act == SDOC_TERM_WR));
    chk(32'(rd_quiet), 32'(act == SDOC_TERM_OFF));
    if (len > 0) begin
      repeat (len - 1) @(posedge pclk);
      #1;
      chk(32'(sdoc_link_if_i.term_sel), 32'(act));
      @(posedge pclk);
      #1;
      chk(32'(sdoc_link_if_i.term_sel), 32'(idle));
    end
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk(rdat, 32'h0000_0010);
    apb(1'b0, 12'h004, 32'h0);
    chk(rdat, 32'h0b00_0009);
    apb(1'b0, 12'h014, 32'h0);
    chk(32'(rerr), 32'h1);
    chk(rdat, 32'h0);
    apb(1'b1, 12'h008, 32'h0000_0321);
    for (int i = 0; i < 8; i++) begin
      wl = 9 - (i[2] ? 3 : 2);
      rl = 11 - (i[2] ? 3 : 2);
      lw = i[1] ? 7 + i[2] : 4 + 2 * !i[0] + i[2];
      lr = (i[0] ? 4 : 6) + i[2];
      apb(1'b1, 12'h000, 32'h10 | 32'(i << 1));
      repeat (2) @(posedge pclk);
      chk(32'(pin_delay), 32'(wl));
      chk(32'(rd_delay), 32'(rl));
      apb(1'b1, 12'h00c, {29'h0, i[0], 2'h2});
      probe(3, wl, lw, SDOC_TERM_PARK, SDOC_TERM_WR);
      apb(1'b1, 12'h00c, 32'h1);
      probe(2, rl, lr, SDOC_TERM_PARK, SDOC_TERM_OFF);
      apb(1'b1, 12'h000, 32'h11 | 32'(i << 1));
      probe(0, wl, 0, SDOC_TERM_PARK, SDOC_TERM_NOM);
      apb(1'b1, 12'h000, 32'h10 | 32'(i << 1));
      probe(1, wl, 0, SDOC_TERM_NOM, SDOC_TERM_PARK);
    end
    apb(1'b1, 12'h000, 32'h11);
    repeat (20) @(posedge pclk);
    apb(1'b1, 12'h00c, 32'h2);
    probe(3, 7, 6, SDOC_TERM_NOM, SDOC_TERM_WR);
    apb(1'b1, 12'h00c, 32'h1);
    probe(2, 9, 6, SDOC_TERM_NOM, SDOC_TERM_OFF);
    apb(1'b1, 12'h000, 32'h10);
    repeat (20) @(posedge pclk);
    apb(1'b1, 12'h00c, 32'h3);
    apb(1'b0, 12'h008, 32'h0);
    chk(rdat, 32'h0000_0301);
    apb(1'b1, 12'h00c, 32'h2);
    probe(3, 7, 1, SDOC_TERM_PARK, SDOC_TERM_PARK);
    apb(1'b1, 12'h008, 32'h0000_0341);
    apb(1'b1, 12'h00c, 32'h2);
    probe(3, 7, 1, SDOC_TERM_PARK, SDOC_TERM_PARK);
    apb(1'b1, 12'h008, 32'h0000_0311);
    apb(1'b1, 12'h00c, 32'h2);
    probe(3, 7, 6, SDOC_TERM_PARK, SDOC_TERM_WR);
    apb(1'b1, 12'h008, 32'h0000_0310);
    apb(1'b1, 12'h000, 32'h11);
    probe(0, 7, 1, SDOC_TERM_PARK, SDOC_TERM_PARK);
    apb(1'b1, 12'h000, 32'h30);
    repeat (4) @(posedge pclk);
    #1;
    chk(32'(sdoc_link_if_i.term_sel), 32'(SDOC_TERM_OFF));
    apb(1'b1, 12'h000, 32'h00);
    repeat (210) @(posedge pclk);
    apb(1'b1, 12'h00c, 32'h2);
    probe(3, 7, 1, SDOC_TERM_PARK, SDOC_TERM_PARK);
    apb(1'b0, 12'h010, 32'h0);
    chk({30'h0, rdat[3:2]}, 32'(SDOC_TERM_PARK));
    print_verdict;
  end
endmodule
`default_nettype wire
